// File: spcz_cfg.svh
// constants for the serial port configuration block
// assumes inclusion by spcz_pkg and spcz_top only
//
// What this block does
// - bit order 0 shifts most significant first, 1 least significant first.
// - bit 3 low gives 3-wire, high gives 4-wire with SDO; ignored in I2C.
// - bit 2 picks the address step between bytes; no effect in I2C.
// - direction 0 decrements the pointer, most significant byte first.
// - direction 1 increments the pointer, least significant byte first.
// - bit 1 set selects least-significant-first; no effect in I2C.
// - soft reset bit 0 starts a configuration download when the store is enabled.
`ifndef SPCZ_CFG_SVH
`define SPCZ_CFG_SVH
`define SPCZ_ADDR_W 15
`define SPCZ_CFG_OFFSET 15'h0000
`define SPCZ_CFG_RESET 8'h00
`define SPCZ_BIT_SOFT 0
`define SPCZ_BIT_LSB 1
`define SPCZ_BIT_ASC 2
`define SPCZ_BIT_OE 3
`define SPCZ_INSTR_LAST 4'hf
`define SPCZ_BYTE_LAST 4'h7
`endif

// File: spcz_pkg.sv
// types shared by the serial port configuration block
// assumes spcz_cfg.svh sits in the include path
`default_nettype none
package spcz_pkg;
  `include "spcz_cfg.svh"
  // configuration byte, bit 7 down to bit 0
  typedef struct packed {
    logic soft_hi;
    logic lsb_hi;
    logic asc_hi;
    logic oe_hi;
    logic oe_lo;
    logic asc_lo;
    logic lsb_lo;
    logic soft_lo;
  } spcz_cfg_t;
  // the settings the port actually acts on
  typedef struct packed {
    logic lsb_first;
    logic ascend;
    logic four_wire;
  } spcz_mode_t;
  typedef enum logic {
    SPCZ_INSTR = 1'b0,
    SPCZ_DATA = 1'b1
  } spcz_state_t;
endpackage
`default_nettype wire

// File: spcz_sync.sv
// two flip-flop synchroniser, one generate bit per lane
// assumes d is static or slow against clk; en freezes both stages
`default_nettype none
module spcz_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q;
      logic s1_d;
      logic s2_q;
      logic s2_d;
      // next stage values, held while en is low
      always_comb begin
        s1_d = en ? d[i] : s1_q;
        s2_d = en ? s1_q : s2_q;
      end
      // two stages; only the second one is read outside
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= s1_d;
          s2_q <= s2_d;
        end
      end
      assign q[i] = s2_q;
    end
  endgenerate
endmodule
`default_nettype wire

// File: spcz_top.sv
// serial port configuration register with its spi shift engine
// assumes sclk idles low, data sampled on rising edge, driven on falling edge;
// frame: 16-bit instruction (read flag, 15-bit address), then data bytes
`default_nettype none
`include "spcz_cfg.svh"
module spcz_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic csb_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic i2c_mode,
  input wire logic store_en,
  output logic download_start,
  output spcz_pkg::spcz_mode_t mode_status
);
  import spcz_pkg::*;

  // ---------------- link domain (sclk) ----------------
  logic frame_rst;
  logic i2c_s;
  spcz_cfg_t cfg_q;
  spcz_cfg_t cfg_d;
  logic soft_tgl_q;
  logic soft_tgl_d;
  spcz_state_t st_q;
  spcz_state_t st_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [15:0] sr_q;
  logic [15:0] sr_d;
  logic rd_q;
  logic rd_d;
  logic [`SPCZ_ADDR_W-1:0] ptr_q;
  logic [`SPCZ_ADDR_W-1:0] ptr_d;
  logic [`SPCZ_ADDR_W-1:0] ptr_next;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic out_q;
  logic out_d;
  spcz_mode_t mode;
  logic [7:0] wbyte;

  assign frame_rst = rst | csb_n;

  // i2c strap brought into the link domain
  spcz_sync #(.W(1)) u_i2c_sync (
    .clk(sclk),
    .rst(rst),
    .en(1'b1),
    .d(i2c_mode),
    .q(i2c_s)
  );

  // effective mode from the lower copies; spi-only bits dropped in i2c
  always_comb begin
    mode.lsb_first = cfg_q.lsb_lo & ~i2c_s;
    mode.ascend = cfg_q.asc_lo & ~i2c_s;
    mode.four_wire = cfg_q.oe_lo & ~i2c_s;
  end

  // pointer step after each data byte
  always_comb begin
    if (mode.ascend) begin
      ptr_next = ptr_q + `SPCZ_ADDR_W'(1);
    end else begin
      ptr_next = ptr_q - `SPCZ_ADDR_W'(1);
    end
  end

  // read mux: only the configuration byte is mapped, the rest reads zero
  function automatic logic [7:0] rdata(input logic [`SPCZ_ADDR_W-1:0] a,
                                       input spcz_cfg_t c);
    rdata = (a == `SPCZ_CFG_OFFSET) ? c : 8'h00;
  endfunction

  // frame engine: shift, count, decode, write and step
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 4'h1;
    rd_d = rd_q;
    ptr_d = ptr_q;
    tx_d = tx_q;
    if (mode.lsb_first) begin
      sr_d = {sdio_i, sr_q[15:1]};
    end else begin
      sr_d = {sr_q[14:0], sdio_i};
    end
    unique case (st_q)
      SPCZ_INSTR: begin
        if (cnt_q == `SPCZ_INSTR_LAST) begin
          st_d = SPCZ_DATA;
          cnt_d = 4'h0;
          rd_d = sr_d[15];
          ptr_d = sr_d[`SPCZ_ADDR_W-1:0];
          tx_d = rdata(sr_d[`SPCZ_ADDR_W-1:0], cfg_q);
        end
      end
      SPCZ_DATA: begin
        if (cnt_q == `SPCZ_BYTE_LAST) begin
          cnt_d = 4'h0;
          ptr_d = ptr_next;
          tx_d = rdata(ptr_next, cfg_q);
        end
      end
    endcase
    if (i2c_s) begin
      st_d = st_q; // spi engine idle while the port runs as i2c
      cnt_d = cnt_q;
    end
  end

  // configuration write and soft reset download request
  // in lsb-first mode the fresh byte sits in the top half of the shifter
  always_comb begin
    wbyte = mode.lsb_first ? sr_d[15:8] : sr_d[7:0];
    cfg_d = cfg_q;
    soft_tgl_d = soft_tgl_q;
    if (!i2c_s && st_q == SPCZ_DATA && cnt_q == `SPCZ_BYTE_LAST && !rd_q &&
        ptr_q == `SPCZ_CFG_OFFSET) begin
      if (wbyte[`SPCZ_BIT_SOFT]) begin
        cfg_d = `SPCZ_CFG_RESET; // soft reset returns defaults
        soft_tgl_d = ~soft_tgl_q;
      end else begin
        cfg_d = wbyte;
      end
    end
  end

  // frame state, cleared whenever chip select is high
  always_ff @(posedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      st_q <= SPCZ_INSTR;
      cnt_q <= 4'h0;
      sr_q <= 16'h0000;
      rd_q <= 1'b0;
      ptr_q <= '0;
      tx_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sr_q <= sr_d;
      rd_q <= rd_d;
      ptr_q <= ptr_d;
      tx_q <= tx_d;
    end
  end

  // configuration survives frames; only the hard reset or a soft reset write clears it
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      cfg_q <= `SPCZ_CFG_RESET;
      soft_tgl_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      soft_tgl_q <= soft_tgl_d;
    end
  end

  // read bit launched on the falling edge in the chosen order
  always_comb begin
    if (mode.lsb_first) begin
      out_d = tx_q[cnt_q[2:0]];
    end else begin
      out_d = tx_q[3'h7 - cnt_q[2:0]];
    end
  end

  always_ff @(negedge sclk or posedge frame_rst) begin
    if (frame_rst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= out_d;
    end
  end

  // read data goes to sdo in 4-wire mode, else back on sdio; neither driver is on in i2c
  assign sdo_o = out_q;
  assign sdio_o = out_q;
  assign sdo_oe = ~frame_rst & rd_q & (st_q == SPCZ_DATA) & mode.four_wire;
  assign sdio_oe = ~frame_rst & rd_q & (st_q == SPCZ_DATA) & ~mode.four_wire & ~i2c_s;

  // ---------------- system domain (clk) ----------------
  logic [4:0] sync_in;
  logic [4:0] sync_out;
  logic tgl_seen_q;
  logic tgl_seen_d;
  logic start_q;
  logic start_d;
  spcz_mode_t mode_q;
  spcz_mode_t mode_d;
  spcz_mode_t mode_prev_q;
  spcz_mode_t mode_prev_d;

  assign sync_in = {store_en, soft_tgl_q, mode};

  // toggle and mode levels cross into clk
  spcz_sync #(.W(5)) u_sys_sync (
    .clk(clk),
    .rst(rst),
    .en(ce),
    .d(sync_in),
    .q(sync_out)
  );

  // toggle edge becomes a one-cycle download start when the store is on;
  // the mode word is taken only after two equal samples, so bits that land
  // in different cycles never show a mixed mode
  always_comb begin
    tgl_seen_d = ce ? sync_out[3] : tgl_seen_q;
    start_d = ce ? ((sync_out[3] ^ tgl_seen_q) & sync_out[4]) : start_q;
    mode_prev_d = ce ? sync_out[2:0] : mode_prev_q;
    mode_d = (ce && sync_out[2:0] == mode_prev_q) ? sync_out[2:0] : mode_q;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgl_seen_q <= 1'b0;
      start_q <= 1'b0;
      mode_q <= '0;
      mode_prev_q <= '0;
    end else begin
      tgl_seen_q <= tgl_seen_d;
      start_q <= start_d;
      mode_q <= mode_d;
      mode_prev_q <= mode_prev_d;
    end
  end

  assign download_start = start_q;
  assign mode_status = mode_q;
endmodule
`default_nettype wire

// File: spcz_checker.sv
// assertions on the configuration port outputs
// assumes binding to spcz_top; every check runs on clk
`default_nettype none
module spcz_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic csb_n,
  input wire logic sdio_oe,
  input wire logic sdo_oe,
  input wire logic store_en,
  input wire logic download_start,
  input wire spcz_pkg::spcz_mode_t mode_status
);
  import spcz_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a new mode must settle, not flicker across the crossing
  sequence mode_hold;
    $stable(mode_status) [*4];
  endsequence
  sequence mode_cleared;
    ##[0:6] (mode_status == 3'b000);
  endsequence
  // read drivers follow the wire mode and stay off outside a frame; a changed mode holds
  oe_excl_a: assert property (!(sdio_oe && sdo_oe))
    else $error("both read drivers on");
  oe_three_a: assert property (sdio_oe |-> !mode_status.four_wire)
    else $error("sdio driven in 4-wire mode");
  oe_four_a: assert property (sdo_oe |-> mode_status.four_wire)
    else $error("sdo driven in 3-wire mode");
  oe_frame_a: assert property (csb_n |-> !(sdio_oe || sdo_oe))
    else $error("driver on outside frame");
  mode_hold_a: assert property ($changed(mode_status) |=> mode_hold)
    else $error("mode unsettled");
  // download request
  dl_pulse_a: assert property (download_start |=> !download_start)
    else $error("download pulse too long");
  dl_store_a: assert property (download_start |-> store_en)
    else $error("download with store off");
  dl_clear_a: assert property (download_start |-> mode_cleared)
    else $error("soft reset left mode set");
endmodule
bind spcz_top spcz_checker spcz_checker_i (.clk(clk), .rst(rst), .csb_n(csb_n),
  .sdio_oe(sdio_oe), .sdo_oe(sdo_oe), .store_en(store_en),
  .download_start(download_start), .mode_status(mode_status));
`default_nettype wire

// File: spcz_host.sv
// spi host model for the configuration port
// assumes sclk idles low between frames, 32 ns period
`default_nettype none
module spcz_host (
  output logic sclk,
  output logic csb_n,
  output logic sdio_i,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic sdo_o,
  input wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;
  logic seen_sdo;
  // shared sdio wire: the device wins while it drives
  assign sdio_i = sdio_oe ? sdio_o : drv;
  initial begin
    sclk = 1'b0;
    csb_n = 1'b1;
    drv = 1'b0;
  end
  // one frame: instruction, then n bytes in the chosen bit order
  task automatic xfer(input logic [15:0] ins, input logic lsb, input int n,
      input logic [15:0] wd, output logic [15:0] rd);
    logic [7:0] b;
    int i;
    csb_n = 1'b0;
    seen_sdo = 1'b0;
    rd = 16'h0;
    #16;
    for (int k = 0; k < 16 + 8 * n; k++) begin
      b = (k < 24) ? wd[15:8] : wd[7:0];
      i = (k - 16) % 8;
      if (k < 16) drv = lsb ? ins[k] : ins[15 - k];
      else if (ins[15]) drv = ~drv; // released line toggles
      else drv = lsb ? b[i] : b[7 - i];
      #16;
      // read bit taken while settled, just before the rising edge
      if (k >= 16) rd[(k < 24 ? 8 : 0) + (lsb ? i : 7 - i)] =
          sdo_oe ? sdo_o : (sdio_oe ? sdio_o : 1'bx);
      seen_sdo |= sdo_oe;
      sclk = 1'b1;
      #16 sclk = 1'b0;
    end
    #16 csb_n = 1'b1;
    #64;
  endtask
endmodule
`default_nettype wire

// File: spcz_top_test.sv
// self-checking bench for the configuration port
// assumes spcz_host drives the link side
`default_nettype none
module spcz_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spcz_pkg::*;
  logic clk, rst, store_en, sclk, csb_n, sdio_i, sdio_o, sdio_oe, sdo_o, sdo_oe, dl;
  logic ce, i2c_mode;
  spcz_mode_t mode_status;
  logic [15:0] rd;
  int err_total, cmp_count, pulses;
  spcz_top spcz_top_i (.clk(clk), .rst(rst), .ce(ce), .sclk(sclk), .csb_n(csb_n),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
    .i2c_mode(i2c_mode), .store_en(store_en), .download_start(dl), .mode_status(mode_status));
  spcz_host spcz_host_i (.sclk(sclk), .csb_n(csb_n), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (dl === 1'b1) pulses++;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [14:0] a, input logic lsb, input int n, input logic [15:0] d);
    spcz_host_i.xfer({1'b0, a}, lsb, n, d, rd);
    repeat (8) @(negedge clk);
  endtask
  // read the register, then judge data, wire and mode
  task automatic rdc(input logic lsb, input logic [7:0] exp, input logic sdo, input logic [2:0] m);
    spcz_host_i.xfer(16'h8000, lsb, 1, 16'h0, rd);
    check(rd[15:8], exp);
    check({7'h0, spcz_host_i.seen_sdo}, {7'h0, sdo});
    check({5'h0, mode_status}, {5'h0, m});
  endtask
  task automatic t_basic;
    rdc(1'b0, 8'h00, 1'b0, 3'b000);
    wr(15'h0, 1'b0, 1, 16'h3000);
    rdc(1'b0, 8'h30, 1'b0, 3'b000);
    wr(15'h0, 1'b0, 1, 16'h1800);
    rdc(1'b0, 8'h18, 1'b1, 3'b001);
  endtask
  task automatic t_step;
    wr(15'h1, 1'b0, 2, 16'h007e);
    rdc(1'b1, 8'h7e, 1'b1, 3'b111);
    wr(15'h1, 1'b1, 2, 16'h0000);
    rdc(1'b1, 8'h7e, 1'b1, 3'b111);
  endtask
  task automatic t_soft;
    store_en = 1'b1;
    pulses = 0;
    wr(15'h0, 1'b1, 1, 16'hff00);
    repeat (12) @(negedge clk);
    check(8'(pulses), 8'h01);
    rdc(1'b0, 8'h00, 1'b0, 3'b000);
    store_en = 1'b0;
    wr(15'h0, 1'b0, 1, 16'h8100);
    repeat (12) @(negedge clk);
    check(8'(pulses), 8'h01);
  endtask
  // strap to i2c: spi-only bits drop out of the mode, config survives
  task automatic t_i2c;
    wr(15'h0, 1'b0, 1, 16'h7e00);
    i2c_mode = 1'b1;
    wr(15'h0, 1'b1, 0, 16'h0000);
    check({5'h0, mode_status}, 8'h00);
    i2c_mode = 1'b0;
    wr(15'h0, 1'b1, 0, 16'h0000);
    rdc(1'b1, 8'h7e, 1'b1, 3'b111);
  endtask
  // clock enable low freezes the reported mode until it returns
  task automatic t_ce;
    ce = 1'b0;
    wr(15'h0, 1'b1, 1, 16'h1800);
    check({5'h0, mode_status}, 8'h07);
    ce = 1'b1;
    repeat (8) @(negedge clk);
    check({5'h0, mode_status}, 8'h01);
  endtask
  task automatic print_verdict;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    store_en = 1'b0;
    ce = 1'b1;
    i2c_mode = 1'b0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_basic();
    t_step();
    t_soft();
    t_i2c();
    t_ce();
    print_verdict();
  end
  // cut a hang short
  initial begin
    #100us;
    err_total++;
    print_verdict();
  end
endmodule
`default_nettype wire
